// ### cdr_defines.svh
`ifndef CDR_DEFINES_SVH
`define CDR_DEFINES_SVH

// byte offsets of the register words on the bus
`define CDR_OFS_INSTRUCTION_LOCATION 8'h00
`define CDR_OFS_ACCUMULATOR_MAIN 8'h04
`define CDR_OFS_ACCUMULATOR_TEMP 8'h08
`define CDR_OFS_INDEX_MODIFIER 8'h0c
`define CDR_OFS_EXTRA_MEMORY_POINTER 8'h10
`define CDR_OFS_STACK_LOCATION 8'h14
`define CDR_OFS_PROGRAM_STATUS_WORD 8'h18

// reset values
`define CDR_REG_RST 16'h0000
// interrupts disabled, level 3, both bank pointers zero
`define CDR_PSW_RST 16'h0030

// fixed memory base of the general-purpose register banks
`define CDR_GP_BASE 16'h0100

// field positions inside the condition codes byte
`define CDR_CCR_HALF_CARRY 7
`define CDR_CCR_INT_ENABLE 6
`define CDR_CCR_LEVEL_HIGH 5
`define CDR_CCR_LEVEL_LOW 4
`define CDR_CCR_NEGATIVE 3
`define CDR_CCR_ZERO 2
`define CDR_CCR_OVERFLOW 1
`define CDR_CCR_CARRY 0

`endif

// ### cdr_pkg.sv
package cdr_pkg;

  typedef enum logic [2:0] {
    CDR_SEL_INSTRUCTION_LOCATION = 3'h0,
    CDR_SEL_ACCUMULATOR_MAIN = 3'h1,
    CDR_SEL_ACCUMULATOR_TEMP = 3'h2,
    CDR_SEL_INDEX_MODIFIER = 3'h3,
    CDR_SEL_EXTRA_MEMORY_POINTER = 3'h4,
    CDR_SEL_STACK_LOCATION = 3'h5,
    CDR_SEL_PROGRAM_STATUS_WORD = 3'h6,
    CDR_SEL_NONE = 3'h7
  } cdr_sel_type;

  typedef struct packed {
    logic [4:0] register_bank_select;
    logic [2:0] direct_bank_select;
    logic [7:0] condition_codes;
  } cdr_psw_type;

  // one arithmetic step on accumulator_main and accumulator_temp
  typedef struct packed {
    logic en;
    logic wide;
    logic sub;
    logic shift;
  } cdr_alu_req_type;

endpackage

// ### cdr_core_regs.sv
// Notes on behaviour
// - 16-bit instruction location register
// - 16-bit accumulator, byte ops use low byte
// - temp accumulator is second operand, low byte on byte ops
// - 16-bit index, extra pointer, stack registers
// - status: bank pointers high, condition codes low
// - direct bank 1..7 remaps offsets 80..ff
// - direct offsets 00..7f never remapped
// - direct bank resets zero, zero means unmapped
// - half carry from bit 3 to 4
// - interrupt enable flag, cleared at reset
// - take interrupt only above current level
// - negative flag copies result msb
// - zero flag set on zero result
// - overflow flag on two's-complement overflow
// - carry from bit 7 (bit 15 on wide steps), shift-out on shifts
// - eight 8-bit registers per bank, 32 banks
// - low three opcode bits pick register
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`include "cdr_defines.svh"

module cdr_core_regs
  import cdr_pkg::*;
#(
  parameter logic [15:0] GP_BASE = `CDR_GP_BASE
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic PC_INC,
  input wire logic CORE_WE,
  input wire cdr_sel_type CORE_SEL,
  input wire logic [15:0] CORE_WDATA,
  input wire cdr_alu_req_type ALU_REQ,
  input wire logic [7:0] DIR_OFFSET,
  input wire logic [2:0] GP_OPCODE,
  input wire logic IRQ_REQ,
  input wire logic [1:0] IRQ_LEVEL,
  output logic [15:0] INSTRUCTION_LOCATION,
  output logic [15:0] ACCUMULATOR_MAIN,
  output logic [15:0] ACCUMULATOR_TEMP,
  output logic [15:0] INDEX_MODIFIER,
  output logic [15:0] EXTRA_MEMORY_POINTER,
  output logic [15:0] STACK_LOCATION,
  output cdr_psw_type PROGRAM_STATUS_WORD,
  output logic [15:0] DIR_PHYS_ADDR,
  output logic [15:0] GP_ADDR,
  output logic IRQ_TAKE
);

  function automatic cdr_sel_type decode_offset(input logic [31:0] addr);
    cdr_sel_type sel;
    sel = CDR_SEL_NONE;
    if (addr[31:8] == 24'h000000) begin
      case (addr[7:0])
        `CDR_OFS_INSTRUCTION_LOCATION: sel = CDR_SEL_INSTRUCTION_LOCATION;
        `CDR_OFS_ACCUMULATOR_MAIN: sel = CDR_SEL_ACCUMULATOR_MAIN;
        `CDR_OFS_ACCUMULATOR_TEMP: sel = CDR_SEL_ACCUMULATOR_TEMP;
        `CDR_OFS_INDEX_MODIFIER: sel = CDR_SEL_INDEX_MODIFIER;
        `CDR_OFS_EXTRA_MEMORY_POINTER: sel = CDR_SEL_EXTRA_MEMORY_POINTER;
        `CDR_OFS_STACK_LOCATION: sel = CDR_SEL_STACK_LOCATION;
        `CDR_OFS_PROGRAM_STATUS_WORD: sel = CDR_SEL_PROGRAM_STATUS_WORD;
        default: sel = CDR_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  function automatic logic [16:0] add_bits(input logic [15:0] x,
                                           input logic [15:0] y,
                                           input logic cin);
    return {1'b0, x} + {1'b0, y} + {16'h0000, cin};
  endfunction

  function automatic logic [15:0] map_direct(input logic [2:0] bank,
                                             input logic [7:0] ofs);
    logic [3:0] win;
    win = {1'b0, bank} + 4'h1;
    if (!ofs[7])
      return {8'h00, ofs};
    else if (bank == 3'h0)
      return {8'h00, ofs};
    else
      return {5'h00, win, ofs[6:0]};
  endfunction

  // the slot of one register, picked by the bus or the core write port
  function automatic logic slot_hit(input logic we, input cdr_sel_type wsel,
                                    input cdr_sel_type slot);
    return we && (wsel == slot);
  endfunction

  // reset value split into the pointer byte and the condition codes
  localparam logic [15:0] PSW_RST = `CDR_PSW_RST;

  logic [15:0] pc_r;
  logic [15:0] acc_main_r;
  logic [15:0] acc_temp_r;
  logic [15:0] index_r;
  logic [15:0] extra_ptr_r;
  logic [15:0] stack_r;
  logic [7:0] psw_hi_r;
  logic [7:0] ccr_r;
  cdr_psw_type psw_w;
  logic [15:0] rd_word;
  logic [1:0] cur_level;
  logic irq_admit;

  logic addr_ph;
  logic wr_pend_r;
  cdr_sel_type wr_sel_r;
  cdr_sel_type rd_sel;
  logic ahb_wr;
  logic [31:0] hrdata_nxt;

  logic [15:0] opa;
  logic [15:0] opb;
  logic [16:0] full_sum;
  logic [16:0] byte_sum;
  logic [16:0] nib_sum;
  logic [15:0] alu_res;
  logic [7:0] ccr_alu;
  logic res_msb;
  logic res_zero;

  assign psw_w = {psw_hi_r, ccr_r};

  // bus side: zero wait states, every answer is OKAY
  assign addr_ph = HSEL & HTRANS[1] & HREADY;
  assign ahb_wr = wr_pend_r & HREADY;
  assign rd_sel = decode_offset(HADDR);

  // a write is only known to land in its data phase, one edge later
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      wr_pend_r <= 1'b0;
    else if (HREADY)
      wr_pend_r <= addr_ph & HWRITE;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      wr_sel_r <= CDR_SEL_NONE;
    else if (HREADY)
      wr_sel_r <= rd_sel;
  end

  // unmapped words read as zero
  always_comb begin
    case (rd_sel)
      CDR_SEL_INSTRUCTION_LOCATION: rd_word = pc_r;
      CDR_SEL_ACCUMULATOR_MAIN: rd_word = acc_main_r;
      CDR_SEL_ACCUMULATOR_TEMP: rd_word = acc_temp_r;
      CDR_SEL_INDEX_MODIFIER: rd_word = index_r;
      CDR_SEL_EXTRA_MEMORY_POINTER: rd_word = extra_ptr_r;
      CDR_SEL_STACK_LOCATION: rd_word = stack_r;
      CDR_SEL_PROGRAM_STATUS_WORD: rd_word = psw_w;
      default: rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    hrdata_nxt = 32'h00000000;
    if (rd_sel != CDR_SEL_NONE) begin
      // a write completing in this same cycle must be seen by the read
      if (ahb_wr && wr_sel_r == rd_sel)
        hrdata_nxt = {16'h0000, HWDATA[15:0]};
      else
        hrdata_nxt = {16'h0000, rd_word};
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      HRDATA <= 32'h00000000;
    else if (addr_ph && !HWRITE)
      HRDATA <= hrdata_nxt;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      HREADYOUT <= 1'b1;
    else
      HREADYOUT <= 1'b1;
  end

  // the slave never errors, so software cannot see a bad offset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      HRESP <= 1'b0;
    else
      HRESP <= 1'b0;
  end

  // arithmetic step: accumulator_main op accumulator_temp
  always_comb begin
    opa = acc_main_r;
    opb = acc_temp_r ^ {16{ALU_REQ.sub}};
    full_sum = add_bits(opa, opb, ALU_REQ.sub);
    byte_sum = add_bits({8'h00, opa[7:0]}, {8'h00, opb[7:0]}, ALU_REQ.sub);
    nib_sum = add_bits({12'h000, opa[3:0]}, {12'h000, opb[3:0]},
                       ALU_REQ.sub);
    ccr_alu = psw_w.condition_codes;
    if (ALU_REQ.shift) begin
      alu_res = {opa[15:8], opa[6:0], 1'b0};
      ccr_alu[`CDR_CCR_CARRY] = opa[7];
    end else if (ALU_REQ.wide) begin
      alu_res = full_sum[15:0];
      // borrow is the inverted carry when subtracting
      ccr_alu[`CDR_CCR_CARRY] = full_sum[16] ^ ALU_REQ.sub;
      ccr_alu[`CDR_CCR_OVERFLOW] = (opa[15] == opb[15]) &&
                                   (full_sum[15] != opa[15]);
    end else begin
      // byte step leaves the upper byte of the accumulator alone
      alu_res = {opa[15:8], byte_sum[7:0]};
      ccr_alu[`CDR_CCR_CARRY] = byte_sum[8] ^ ALU_REQ.sub;
      ccr_alu[`CDR_CCR_OVERFLOW] = (opa[7] == opb[7]) &&
                                   (byte_sum[7] != opa[7]);
    end
    if (!ALU_REQ.shift)
      ccr_alu[`CDR_CCR_HALF_CARRY] = nib_sum[4] ^ ALU_REQ.sub;
    res_msb = ALU_REQ.wide && !ALU_REQ.shift ? alu_res[15] : alu_res[7];
    res_zero = ALU_REQ.wide && !ALU_REQ.shift ? (alu_res == 16'h0000) :
               (alu_res[7:0] == 8'h00);
    ccr_alu[`CDR_CCR_NEGATIVE] = res_msb;
    ccr_alu[`CDR_CCR_ZERO] = res_zero;
  end

  // each register: bus write beats core write beats its own update
  // the counter wraps at the top of the 64K space
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      pc_r <= `CDR_REG_RST;
    else if (slot_hit(ahb_wr, wr_sel_r, CDR_SEL_INSTRUCTION_LOCATION))
      pc_r <= HWDATA[15:0];
    else if (slot_hit(CORE_WE, CORE_SEL, CDR_SEL_INSTRUCTION_LOCATION))
      pc_r <= CORE_WDATA;
    else if (PC_INC)
      pc_r <= pc_r + 16'h0001;
  end

  // a lost arithmetic step is dropped, not retried
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      acc_main_r <= `CDR_REG_RST;
    else if (slot_hit(ahb_wr, wr_sel_r, CDR_SEL_ACCUMULATOR_MAIN))
      acc_main_r <= HWDATA[15:0];
    else if (slot_hit(CORE_WE, CORE_SEL, CDR_SEL_ACCUMULATOR_MAIN))
      acc_main_r <= CORE_WDATA;
    else if (ALU_REQ.en)
      acc_main_r <= alu_res;
  end

  // the second operand is only ever loaded, never computed
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      acc_temp_r <= `CDR_REG_RST;
    else if (slot_hit(ahb_wr, wr_sel_r, CDR_SEL_ACCUMULATOR_TEMP))
      acc_temp_r <= HWDATA[15:0];
    else if (slot_hit(CORE_WE, CORE_SEL, CDR_SEL_ACCUMULATOR_TEMP))
      acc_temp_r <= CORE_WDATA;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      index_r <= `CDR_REG_RST;
    else if (slot_hit(ahb_wr, wr_sel_r, CDR_SEL_INDEX_MODIFIER))
      index_r <= HWDATA[15:0];
    else if (slot_hit(CORE_WE, CORE_SEL, CDR_SEL_INDEX_MODIFIER))
      index_r <= CORE_WDATA;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      extra_ptr_r <= `CDR_REG_RST;
    else if (slot_hit(ahb_wr, wr_sel_r, CDR_SEL_EXTRA_MEMORY_POINTER))
      extra_ptr_r <= HWDATA[15:0];
    else if (slot_hit(CORE_WE, CORE_SEL, CDR_SEL_EXTRA_MEMORY_POINTER))
      extra_ptr_r <= CORE_WDATA;
  end

  // no bounds check here: the stack may wrap through memory
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      stack_r <= `CDR_REG_RST;
    else if (slot_hit(ahb_wr, wr_sel_r, CDR_SEL_STACK_LOCATION))
      stack_r <= HWDATA[15:0];
    else if (slot_hit(CORE_WE, CORE_SEL, CDR_SEL_STACK_LOCATION))
      stack_r <= CORE_WDATA;
  end

  // bank pointers change only by explicit writes
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      psw_hi_r <= PSW_RST[15:8];
    else if (slot_hit(ahb_wr, wr_sel_r, CDR_SEL_PROGRAM_STATUS_WORD))
      psw_hi_r <= HWDATA[15:8];
    else if (slot_hit(CORE_WE, CORE_SEL, CDR_SEL_PROGRAM_STATUS_WORD))
      psw_hi_r <= CORE_WDATA[15:8];
  end

  // a status write in the same cycle drops the flag update
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      ccr_r <= PSW_RST[7:0];
    else if (slot_hit(ahb_wr, wr_sel_r, CDR_SEL_PROGRAM_STATUS_WORD))
      ccr_r <= HWDATA[7:0];
    else if (slot_hit(CORE_WE, CORE_SEL, CDR_SEL_PROGRAM_STATUS_WORD))
      ccr_r <= CORE_WDATA[7:0];
    else if (ALU_REQ.en)
      ccr_r <= ccr_alu;
  end

  assign INSTRUCTION_LOCATION = pc_r;
  assign ACCUMULATOR_MAIN = acc_main_r;
  assign ACCUMULATOR_TEMP = acc_temp_r;
  assign INDEX_MODIFIER = index_r;
  assign EXTRA_MEMORY_POINTER = extra_ptr_r;
  assign STACK_LOCATION = stack_r;
  assign PROGRAM_STATUS_WORD = psw_w;

  // address helpers follow the status word one cycle later
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      DIR_PHYS_ADDR <= 16'h0000;
    else
      DIR_PHYS_ADDR <= map_direct(psw_w.direct_bank_select, DIR_OFFSET);
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      GP_ADDR <= 16'h0000;
    else
      GP_ADDR <= GP_BASE + {8'h00, psw_w.register_bank_select, 3'h0} +
                 {13'h0000, GP_OPCODE};
  end

  // lower level number is higher priority; level 3 admits 0 to 2
  assign cur_level = {psw_w.condition_codes[`CDR_CCR_LEVEL_HIGH],
                      psw_w.condition_codes[`CDR_CCR_LEVEL_LOW]};
  assign irq_admit = IRQ_REQ &
                     psw_w.condition_codes[`CDR_CCR_INT_ENABLE] &
                     (IRQ_LEVEL < cur_level);

  // registered so the decision never races a status write
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      IRQ_TAKE <= 1'b0;
    else
      IRQ_TAKE <= irq_admit;
  end

endmodule

// ### cdr_core_regs_props.sv
`timescale 1ns/100ps
module cdr_core_regs_props
  import cdr_pkg::*;
#(
  parameter logic [15:0] GP_BASE = 16'h0100
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic HWRITE,
  input wire logic CORE_WE,
  input wire cdr_alu_req_type ALU_REQ,
  input wire logic [15:0] ACCUMULATOR_MAIN,
  input wire logic [15:0] ACCUMULATOR_TEMP,
  input wire cdr_psw_type PROGRAM_STATUS_WORD,
  input wire logic [7:0] DIR_OFFSET,
  input wire logic [15:0] DIR_PHYS_ADDR,
  input wire logic [2:0] GP_OPCODE,
  input wire logic [15:0] GP_ADDR,
  input wire logic IRQ_REQ,
  input wire logic [1:0] IRQ_LEVEL,
  input wire logic IRQ_TAKE
);
  logic [7:0] cc, a, t;
  logic [2:0] db;
  logic [4:0] rb, hs;
  logic [8:0] sum;
  logic bw, ov, irq_ok;
  assign cc = PROGRAM_STATUS_WORD.condition_codes;
  assign db = PROGRAM_STATUS_WORD.direct_bank_select;
  assign rb = PROGRAM_STATUS_WORD.register_bank_select;
  assign a = ACCUMULATOR_MAIN[7:0];
  assign t = ACCUMULATOR_TEMP[7:0];
  assign sum = {1'b0, a} + {1'b0, t};
  assign hs = {1'b0, a[3:0]} + {1'b0, t[3:0]};
  assign ov = (a[7] == t[7]) && (sum[7] != a[7]);
  assign bw = HSEL && HWRITE;
  assign irq_ok = IRQ_REQ && cc[6] && (IRQ_LEVEL < cc[5:4]);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // a bus or core write in the same cycle wins over the alu step
  sequence s_quiet;
    !CORE_WE && !$past(bw);
  endsequence
  sequence s_add;
    ALU_REQ == 4'b1000 ##0 s_quiet;
  endsequence
  property p_add;
    s_add |=> {cc[0], a} == $past(sum);
  endproperty
  a_add: assert property (p_add) else $error("byte add");
  property p_half;
    s_add |=> cc[7] == ($past(hs) > 5'h0f);
  endproperty
  a_half: assert property (p_half) else $error("half carry");
  property p_nzv;
    s_add |=> cc[3] == a[7] && cc[2] == (a == 8'h00) && cc[1] == $past(ov);
  endproperty
  a_nzv: assert property (p_nzv) else $error("nzv flags");
  property p_shift;
    ALU_REQ == 4'b1001 ##0 s_quiet |=>
      cc[0] == $past(a[7]) && a == {$past(a[6:0]), 1'b0};
  endproperty
  a_shift: assert property (p_shift) else $error("shift carry");
  property p_dir_same;
    !DIR_OFFSET[7] || db == 3'h0 |=> DIR_PHYS_ADDR == {8'h00, $past(DIR_OFFSET)};
  endproperty
  a_dir_same: assert property (p_dir_same) else $error("dir same");
  property p_dir_map;
    DIR_OFFSET[7] && db != 3'h0 |=> DIR_PHYS_ADDR ==
      {5'h00, {1'b0, $past(db)} + 4'h1, $past(DIR_OFFSET[6:0])};
  endproperty
  a_dir_map: assert property (p_dir_map) else $error("dir map");
  property p_gp;
    1'b1 |=> GP_ADDR == GP_BASE + {8'h00, $past(rb), 3'h0} +
      {13'h0000, $past(GP_OPCODE)};
  endproperty
  a_gp: assert property (p_gp) else $error("gp addr");
  property p_irq_on;
    irq_ok |=> IRQ_TAKE;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missed");
  property p_irq_off;
    !irq_ok |=> !IRQ_TAKE;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq taken");
endmodule

bind cdr_core_regs cdr_core_regs_props #(.GP_BASE(GP_BASE))
  i_cdr_core_regs_props (.*);

// ### cdr_core_regs_test.sv
`timescale 1ns/100ps
module cdr_core_regs_test;
  import cdr_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic pc_inc = 1'b0, core_we = 1'b0, irq_req = 1'b0, hrdy, irq_take;
  logic hresp;
  logic [15:0] acc_a, acc_t, ep, sp;
  cdr_psw_type psw;
  logic [1:0] htrans = 2'h0, irq_level = 2'h0;
  logic [2:0] gp_op = 3'h0;
  logic [7:0] dir_ofs = 8'h85;
  logic [15:0] core_wdata = 16'h0000, pc, ix, dir_phys, gp_addr;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  cdr_sel_type core_sel = CDR_SEL_NONE;
  cdr_alu_req_type alu_req = '0;
  int errors = 0, compares = 0, e;
  // columns: a, t, status, step kind, result a, result status
  logic [15:0] tab [3][6] = '{
    '{16'h1188, 16'h0088, 16'h0030, 16'h0008, 16'h1110, 16'h00b3},
    '{16'h0080, 16'h0000, 16'h00b2, 16'h0009, 16'h0000, 16'h00b7},
    '{16'h0001, 16'h0002, 16'h0030, 16'h000a, 16'h00ff, 16'h00b9}};

  cdr_core_regs i_cdr_core_regs (
    .CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
    .PC_INC(pc_inc), .CORE_WE(core_we), .CORE_SEL(core_sel),
    .CORE_WDATA(core_wdata), .ALU_REQ(alu_req), .DIR_OFFSET(dir_ofs),
    .GP_OPCODE(gp_op), .IRQ_REQ(irq_req), .IRQ_LEVEL(irq_level),
    .INSTRUCTION_LOCATION(pc), .ACCUMULATOR_MAIN(acc_a),
    .ACCUMULATOR_TEMP(acc_t), .INDEX_MODIFIER(ix),
    .EXTRA_MEMORY_POINTER(ep), .STACK_LOCATION(sp),
    .PROGRAM_STATUS_WORD(psw), .DIR_PHYS_ADDR(dir_phys), .GP_ADDR(gp_addr),
    .IRQ_TAKE(irq_take));

  always #5 clk = ~clk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task wait_rdy;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
  endtask

  // a read compares its data word against d
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    if (w) hwdata <= d;
    wait_rdy;
    if (!w) check(hrdata, d);
    check({31'h0, hresp}, 32'h0);
  endtask

  task end_sim;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    step(6);
    rst_b <= 1'b1;
    step(1);
    for (int i = 0; i < 8; i++)
      ahb(1'b0, 8'(4 * i), (i == 6) ? 32'h30 : 32'h0);
    check({16'h0, dir_phys}, 32'h85);
    $display("done: reset");
    for (int i = 0; i < 8; i++) begin
      ahb(1'b1, 8'(4 * i), {16'hffff, 16'h1a5 + 16'(i)});
      e = (i == 7) ? 0 : 421 + i;
      ahb(1'b0, 8'(4 * i), 32'(e));
    end
    core_sel <= CDR_SEL_INDEX_MODIFIER;
    core_wdata <= 16'h5a3c;
    core_we <= 1'b1;
    pc_inc <= 1'b1;
    step(1);
    core_we <= 1'b0;
    step(1);
    pc_inc <= 1'b0;
    step(1);
    check({16'h0, ix}, 32'h5a3c);
    check({16'h0, pc}, 32'h1a7);
    check({16'h0, acc_a}, 32'h1a6);
    check({16'h0, acc_t}, 32'h1a7);
    check({16'h0, ep}, 32'h1a9);
    check({16'h0, sp}, 32'h1aa);
    check({16'h0, psw}, 32'h1ab);
    $display("done: registers");
    for (int d = 0; d < 8; d++) begin
      gp_op <= 3'(d);
      ahb(1'b1, 8'h18, {16'h0, 5'(4 * d + 3), 3'(d), 8'h30});
      for (int o = 0; o < 2; o++) begin
        dir_ofs <= (o != 0) ? 8'h85 : 8'h05;
        step(2);
        e = (o != 0 && d != 0) ? 128 * (d + 1) + 5 : 5 + 128 * o;
        check({16'h0, dir_phys}, 32'(e));
      end
      check({16'h0, gp_addr}, 32'(256 + 8 * (4 * d + 3) + d));
    end
    $display("done: mapping");
    for (int i = 0; i < 3; i++) begin
      ahb(1'b1, 8'h04, {16'h0, tab[i][0]});
      ahb(1'b1, 8'h08, {16'h0, tab[i][1]});
      ahb(1'b1, 8'h18, {16'h0, tab[i][2]});
      alu_req <= cdr_alu_req_type'(tab[i][3][3:0]);
      step(1);
      alu_req <= '0;
      step(1);
      ahb(1'b0, 8'h04, {16'h0, tab[i][4]});
      ahb(1'b0, 8'h18, {16'h0, tab[i][5]});
    end
    $display("done: arithmetic");
    irq_req <= 1'b1;
    for (int p = 0; p < 5; p++) begin
      irq_level <= 2'(p);
      ahb(1'b1, 8'h18, (p == 4) ? 32'h20 : 32'h60);
      step(2);
      check({31'h0, irq_take}, (p < 2) ? 32'h1 : 32'h0);
    end
    $display("done: interrupts");
    end_sim;
  end

  initial begin
    step(5000);
    errors++;
    end_sim;
  end
endmodule
